// ---- common/dbu_params.svh ----
// Register indices, field positions, masks and codes of the debug breakpoint unit.
// Assumes word indices on the bus; byte address is four times the index.
`ifndef DBU_PARAMS_SVH
`define DBU_PARAMS_SVH

`define DBU_IDX_PC      8'h11
`define DBU_IDX_SP      8'h12
`define DBU_IDX_TNUM    8'h13
`define DBU_IDX_TREG    8'h14
`define DBU_IDX_TYPE    8'h15
`define DBU_IDX_DATA    8'h16
`define DBU_IDX_RUN     8'h18
`define DBU_IDX_SCR     8'h20
`define DBU_IDX_IBA     8'h30
`define DBU_IDX_IBC     8'h40
`define DBU_IDX_DWA1    8'h50
`define DBU_IDX_DWA2    8'h60
`define DBU_IDX_DWC     8'h70
`define DBU_IDX_RWM     8'h80
`define DBU_IDX_RWV     8'h90
`define DBU_IDX_RWC     8'h9c

`define DBU_CTL_EN      0
`define DBU_CTL_COND    1
`define DBU_CTL_LOAD    2
`define DBU_CTL_THR     23:16
`define DBU_TYPE_UNIT   17:16
`define DBU_TYPE_THR    15:8
`define DBU_TYPE_CAUSE  2:0

`define DBU_MASK_TNUM   32'h0000_00ff
`define DBU_MASK_TREG   32'h0000_001f
`define DBU_MASK_TYPE   32'h0003_ff07
`define DBU_MASK_RUN    32'h0000_00ff
`define DBU_MASK_IBC    32'h00ff_0003
`define DBU_MASK_DWC    32'h00ff_0007
`define DBU_MASK_RWC    32'h00ff_0003

`define DBU_CAUSE_NONE  3'h0
`define DBU_CAUSE_HOST  3'h1
`define DBU_CAUSE_CALL  3'h2
`define DBU_CAUSE_IBRK  3'h3
`define DBU_CAUSE_DWAT  3'h4
`define DBU_CAUSE_RWAT  3'h5

`define DBU_RST_WORD    32'h0000_0000

`endif

// ---- common/dbu_pkg.sv ----
// Types of the debug breakpoint unit.
// Assumes dbu_params.svh for all numeric constants.
`default_nettype none

package dbu_pkg;

  typedef enum logic [1:0] {DBU_IDLE, DBU_PEND, DBU_DEBUG} dbu_mode_t;

  typedef struct packed {
    dbu_mode_t         mode;
    logic              debug_req;
    logic              in_debug;
    logic [7:0]        halt;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [31:0]       cfg_rdata;
    logic [31:0]       saved_pc;
    logic [31:0]       saved_sp;
    logic [7:0]        tnum;
    logic [4:0]        treg;
    logic [2:0]        cause;
    logic [1:0]        unit;
    logic [7:0]        thr;
    logic [31:0]       data;
    logic [7:0]        run_mask;
    logic [7:0][31:0]  scr;
    logic [3:0][31:0]  iba;
    logic [3:0][31:0]  ibc;
    logic [3:0][31:0]  dwa1;
    logic [3:0][31:0]  dwa2;
    logic [3:0][31:0]  dwc;
    logic [3:0][31:0]  rwm;
    logic [3:0][31:0]  rwv;
    logic [3:0][31:0]  rwc;
  } dbu_state_t;

endpackage

`default_nettype wire

// ---- hw/dbu_top.sv ----
// Debug breakpoint unit: saved context, cause record, run mask, mailbox and watch units.
// Assumes core-side inputs are on CLK; registers reached over Avalon-MM with waitrequest.
`include "dbu_params.svh"
`default_nettype none

module dbu_top #(
  parameter int ADDR_W = 10
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic [ADDR_W-1:0] ADDRESS,
  input  wire logic              READ,
  input  wire logic              WRITE,
  input  wire logic [31:0]       WRITEDATA,
  input  wire logic [3:0]        BYTEENABLE,
  output logic      [31:0]       READDATA,
  output logic                   WAITREQUEST,
  input  wire logic              HOST_REQ,
  input  wire logic              CALL_VALID,
  input  wire logic [2:0]        CALL_THREAD,
  input  wire logic              PC_VALID,
  input  wire logic [2:0]        PC_THREAD,
  input  wire logic [31:0]       PC_VALUE,
  input  wire logic              MEM_VALID,
  input  wire logic [2:0]        MEM_THREAD,
  input  wire logic              MEM_LOAD,
  input  wire logic [31:0]       MEM_ADDR,
  input  wire logic              RES_VALID,
  input  wire logic [2:0]        RES_THREAD,
  input  wire logic [31:0]       RES_ID,
  input  wire logic              ENTRY_STROBE,
  input  wire logic [31:0]       ENTRY_PC,
  input  wire logic [31:0]       ENTRY_SP,
  input  wire logic              DEBUG_RETURN,
  output logic                   DEBUG_REQ,
  output logic                   IN_DEBUG,
  output logic      [7:0]        THREAD_HALT,
  output logic      [7:0]        STATE_READ_THREAD,
  output logic      [4:0]        STATE_READ_REG,
  input  wire logic              CFG_WRITE,
  input  wire logic [2:0]        CFG_INDEX,
  input  wire logic [31:0]       CFG_WDATA,
  output logic      [31:0]       CFG_RDATA
);

  dbu_pkg::dbu_state_t s;
  dbu_pkg::dbu_state_t n;

  logic [7:0]  idx;
  logic [3:0]  ib_hit;
  logic [3:0]  dw_hit;
  logic [3:0]  rw_hit;
  logic [1:0]  ib_unit;
  logic [1:0]  dw_unit;
  logic [1:0]  rw_unit;
  logic [31:0] rd;
  logic        cond_a;
  logic        cond_b;

  function automatic logic thr_en(input logic [31:0] ctrl, input logic [2:0] t);
    logic [7:0] f;
    f = ctrl[`DBU_CTL_THR];
    return f[t];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  function automatic logic [1:0] lowest(input logic [3:0] h);
    logic [1:0] u;
    u = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (h[i]) begin
        u = 2'(i);
      end
    end
    return u;
  endfunction

  always_comb begin
    n      = s;
    idx    = ADDRESS[ADDR_W-1:2];
    cond_a = 1'b0;
    cond_b = 1'b0;
    rd     = `DBU_RST_WORD;

    // Watch comparators
    for (int i = 0; i < 4; i++) begin
      ib_hit[i] = PC_VALID && s.ibc[i][`DBU_CTL_EN] && thr_en(s.ibc[i], PC_THREAD) &&
                  (s.ibc[i][`DBU_CTL_COND] ? (PC_VALUE != s.iba[i])
                                           : (PC_VALUE == s.iba[i]));
      cond_a    = MEM_ADDR >= s.dwa1[i];
      cond_b    = MEM_ADDR <= s.dwa2[i];
      dw_hit[i] = MEM_VALID && s.dwc[i][`DBU_CTL_EN] && thr_en(s.dwc[i], MEM_THREAD) &&
                  (!MEM_LOAD || s.dwc[i][`DBU_CTL_LOAD]) &&
                  (s.dwc[i][`DBU_CTL_COND] ? (cond_a || cond_b) : (cond_a && cond_b));
      rw_hit[i] = RES_VALID && s.rwc[i][`DBU_CTL_EN] && thr_en(s.rwc[i], RES_THREAD) &&
                  (s.rwc[i][`DBU_CTL_COND] ^
                   ((RES_ID & s.rwm[i]) == (s.rwv[i] & s.rwm[i])));
    end
    ib_unit = lowest(ib_hit);
    dw_unit = lowest(dw_hit);
    rw_unit = lowest(rw_hit);

    // Register read view
    unique case (idx)
      `DBU_IDX_PC:   rd = s.saved_pc;
      `DBU_IDX_SP:   rd = s.saved_sp;
      `DBU_IDX_TNUM: rd = {24'h0, s.tnum};
      `DBU_IDX_TREG: rd = {27'h0, s.treg};
      `DBU_IDX_TYPE: rd = {14'h0, s.unit, s.thr, 5'h0, s.cause};
      `DBU_IDX_DATA: rd = s.data;
      `DBU_IDX_RUN:  rd = {24'h0, s.run_mask};
      default:       rd = `DBU_RST_WORD;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (idx == 8'(`DBU_IDX_SCR + i)) rd = s.scr[i];
    end
    for (int i = 0; i < 4; i++) begin
      if (idx == 8'(`DBU_IDX_IBA + i)) rd = s.iba[i];
      if (idx == 8'(`DBU_IDX_IBC + i)) rd = s.ibc[i];
      if (idx == 8'(`DBU_IDX_DWA1 + i)) rd = s.dwa1[i];
      if (idx == 8'(`DBU_IDX_DWA2 + i)) rd = s.dwa2[i];
      if (idx == 8'(`DBU_IDX_DWC + i)) rd = s.dwc[i];
      if (idx == 8'(`DBU_IDX_RWM + i)) rd = s.rwm[i];
      if (idx == 8'(`DBU_IDX_RWV + i)) rd = s.rwv[i];
      if (idx == 8'(`DBU_IDX_RWC + i)) rd = s.rwc[i];
    end

    // Mailbox from the configuration side; the bus overrides it below
    if (CFG_WRITE) begin
      n.scr[CFG_INDEX] = CFG_WDATA;
    end
    n.cfg_rdata = s.scr[CFG_INDEX];

    // Bus handshake: one wait cycle, then the access completes
    if ((READ || WRITE) && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata   = rd;
    end else if (!s.waitreq) begin
      n.waitreq = 1'b1;
      if (WRITE) begin
        unique case (idx)
          `DBU_IDX_PC:   n.saved_pc = merge(s.saved_pc, WRITEDATA, BYTEENABLE, '1);
          `DBU_IDX_SP:   n.saved_sp = merge(s.saved_sp, WRITEDATA, BYTEENABLE, '1);
          `DBU_IDX_TNUM: n.tnum = 8'(merge({24'h0, s.tnum}, WRITEDATA, BYTEENABLE, `DBU_MASK_TNUM));
          `DBU_IDX_TREG: n.treg = 5'(merge({27'h0, s.treg}, WRITEDATA, BYTEENABLE, `DBU_MASK_TREG));
          `DBU_IDX_TYPE: begin
            rd      = merge(rd, WRITEDATA, BYTEENABLE, `DBU_MASK_TYPE);
            n.unit  = rd[`DBU_TYPE_UNIT];
            n.thr   = rd[`DBU_TYPE_THR];
            n.cause = rd[`DBU_TYPE_CAUSE];
          end
          `DBU_IDX_DATA: n.data = merge(s.data, WRITEDATA, BYTEENABLE, '1);
          `DBU_IDX_RUN:  n.run_mask = 8'(merge({24'h0, s.run_mask}, WRITEDATA, BYTEENABLE, `DBU_MASK_RUN));
          default:       ;
        endcase
        for (int i = 0; i < 8; i++) begin
          if (idx == 8'(`DBU_IDX_SCR + i)) n.scr[i] = merge(s.scr[i], WRITEDATA, BYTEENABLE, '1);
        end
        for (int i = 0; i < 4; i++) begin
          if (idx == 8'(`DBU_IDX_IBA + i)) n.iba[i] = merge(s.iba[i], WRITEDATA, BYTEENABLE, '1);
          if (idx == 8'(`DBU_IDX_IBC + i)) n.ibc[i] = merge(s.ibc[i], WRITEDATA, BYTEENABLE, `DBU_MASK_IBC);
          if (idx == 8'(`DBU_IDX_DWA1 + i)) n.dwa1[i] = merge(s.dwa1[i], WRITEDATA, BYTEENABLE, '1);
          if (idx == 8'(`DBU_IDX_DWA2 + i)) n.dwa2[i] = merge(s.dwa2[i], WRITEDATA, BYTEENABLE, '1);
          if (idx == 8'(`DBU_IDX_DWC + i)) n.dwc[i] = merge(s.dwc[i], WRITEDATA, BYTEENABLE, `DBU_MASK_DWC);
          if (idx == 8'(`DBU_IDX_RWM + i)) n.rwm[i] = merge(s.rwm[i], WRITEDATA, BYTEENABLE, '1);
          if (idx == 8'(`DBU_IDX_RWV + i)) n.rwv[i] = merge(s.rwv[i], WRITEDATA, BYTEENABLE, '1);
          if (idx == 8'(`DBU_IDX_RWC + i)) n.rwc[i] = merge(s.rwc[i], WRITEDATA, BYTEENABLE, `DBU_MASK_RWC);
        end
      end
    end

    // Debug sequencing; hardware updates win over a same-cycle bus write
    unique case (s.mode)
      dbu_pkg::DBU_IDLE: begin
        if (HOST_REQ) begin
          n.cause = `DBU_CAUSE_HOST;
          n.unit  = 2'h0;
          n.thr   = 8'h0;
        end else if (CALL_VALID) begin
          n.cause = `DBU_CAUSE_CALL;
          n.unit  = 2'h0;
          n.thr   = {5'h0, CALL_THREAD};
        end else if (|ib_hit) begin
          n.cause = `DBU_CAUSE_IBRK;
          n.unit  = ib_unit;
          n.thr   = {5'h0, PC_THREAD};
        end else if (|dw_hit) begin
          n.cause = `DBU_CAUSE_DWAT;
          n.unit  = dw_unit;
          n.thr   = {5'h0, MEM_THREAD};
          n.data  = MEM_ADDR;
        end else if (|rw_hit) begin
          n.cause = `DBU_CAUSE_RWAT;
          n.unit  = rw_unit;
          n.thr   = {5'h0, RES_THREAD};
          n.data  = RES_ID;
        end
        if (HOST_REQ || CALL_VALID || |ib_hit || |dw_hit || |rw_hit) begin
          n.mode      = dbu_pkg::DBU_PEND;
          n.debug_req = 1'b1;
        end
      end
      dbu_pkg::DBU_PEND: begin
        if (ENTRY_STROBE) begin
          n.saved_pc  = ENTRY_PC;
          n.saved_sp  = ENTRY_SP;
          n.debug_req = 1'b0;
          n.in_debug  = 1'b1;
          n.mode      = dbu_pkg::DBU_DEBUG;
        end
      end
      dbu_pkg::DBU_DEBUG: begin
        if (DEBUG_RETURN) begin
          n.in_debug = 1'b0;
          n.mode     = dbu_pkg::DBU_IDLE;
        end
      end
      default: n.mode = dbu_pkg::DBU_IDLE;
    endcase

    n.halt = n.in_debug ? 8'h0 : n.run_mask;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s         <= '0;
      s.mode    <= dbu_pkg::DBU_IDLE;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign READDATA          = s.rdata;
  assign WAITREQUEST       = s.waitreq;
  assign DEBUG_REQ         = s.debug_req;
  assign IN_DEBUG          = s.in_debug;
  assign THREAD_HALT       = s.halt;
  assign STATE_READ_THREAD = s.tnum;
  assign STATE_READ_REG    = s.treg;
  assign CFG_RDATA         = s.cfg_rdata;

  AST_PC_CAPTURE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_PEND && ENTRY_STROBE) |=> (s.saved_pc == $past(ENTRY_PC) && IN_DEBUG))
    else $error("saved pc not captured on entry");

  AST_SP_CAPTURE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_PEND && ENTRY_STROBE) |=> (s.saved_sp == $past(ENTRY_SP) && !DEBUG_REQ))
    else $error("saved sp not captured on entry");

  AST_CAUSE_RANGE: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(DEBUG_REQ) |-> (s.cause >= `DBU_CAUSE_HOST && s.cause <= `DBU_CAUSE_RWAT))
    else $error("cause code out of range on request");

  AST_HOST_ZERO: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_IDLE && HOST_REQ) |=> (s.cause == `DBU_CAUSE_HOST && s.thr == 8'h0 && s.unit == 2'h0))
    else $error("host request fields wrong");

  AST_CALL_FIELDS: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_IDLE && !HOST_REQ && CALL_VALID)
    |=> (s.cause == `DBU_CAUSE_CALL && s.unit == 2'h0 && s.thr == {5'h0, $past(CALL_THREAD)}))
    else $error("debug call fields wrong");

  AST_IBRK_FIRE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_IDLE && !HOST_REQ && !CALL_VALID && |ib_hit)
    |=> (DEBUG_REQ && s.cause == `DBU_CAUSE_IBRK && s.unit == $past(ib_unit)))
    else $error("code breakpoint not taken");

  AST_IBRK_THREAD: assert property (@(posedge CLK) disable iff (SYS_RST)
    (PC_VALID && !thr_en(s.ibc[0], PC_THREAD)) |-> !ib_hit[0])
    else $error("code breakpoint fired for disabled thread");

  AST_DWAT_DATA: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_IDLE && !HOST_REQ && !CALL_VALID && !(|ib_hit) && |dw_hit)
    |=> (s.data == $past(MEM_ADDR) && s.cause == `DBU_CAUSE_DWAT))
    else $error("watch address not recorded");

  AST_RWAT_DATA: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_IDLE && !HOST_REQ && !CALL_VALID && !(|ib_hit) && !(|dw_hit) && |rw_hit)
    |=> (s.data == $past(RES_ID) && s.cause == `DBU_CAUSE_RWAT))
    else $error("resource id not recorded");

  AST_HALT_RETURN: assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(IN_DEBUG) |-> (THREAD_HALT == s.run_mask) ##1 (IN_DEBUG || THREAD_HALT == s.run_mask))
    else $error("run mask not applied after return");

  AST_HALT_IN_DEBUG: assert property (@(posedge CLK) disable iff (SYS_RST)
    IN_DEBUG |-> (THREAD_HALT == 8'h0))
    else $error("threads halted while in debug");

  // Cause fields load on the same edge that raises the request, so only held requests are checked
  AST_SINGLE_REQ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (DEBUG_REQ && $past(DEBUG_REQ))
    |-> ($stable(s.cause) && $stable(s.unit) && $stable(s.thr) && $stable(s.data)))
    else $error("cause fields changed while request pending");

  AST_PEND_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s.mode == dbu_pkg::DBU_PEND && !ENTRY_STROBE) |=> (DEBUG_REQ && !IN_DEBUG))
    else $error("request dropped before entry");

  AST_BUS_ANSWER: assert property (@(posedge CLK) disable iff (SYS_RST)
    ((READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer not within one cycle");

endmodule

`default_nettype wire

// ---- bench/dbu_core_model.sv ----
// Core-side model: enters the debug handler a set number of cycles after a request, returns on demand.
// Assumes the unit's request and debug-state outputs on the same clock as this model.
`default_nettype none

module dbu_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        debug_req,
  input  wire logic        in_debug,
  input  wire logic [3:0]  lat,
  input  wire logic        release_req,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] sp,
  output logic             entry_strobe,
  output logic [31:0]      entry_pc,
  output logic [31:0]      entry_sp,
  output logic             debug_return
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  // Context lines carry nothing useful outside the strobe
  assign entry_pc = entry_strobe ? pc : ~pc;
  assign entry_sp = entry_strobe ? sp : ~sp;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt          <= 4'h0;
      entry_strobe <= 1'b0;
      debug_return <= 1'b0;
    end else begin
      entry_strobe <= 1'b0;
      cnt          <= 4'h0;
      if (debug_req && !entry_strobe) begin
        if (cnt == lat) entry_strobe <= 1'b1;
        else cnt <= cnt + 4'h1;
      end
      debug_return <= in_debug & release_req & ~debug_return;
    end
  end
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench of the debug breakpoint unit: registers over Avalon-MM, triggers, entry and return.
// Assumes dbu_top with default address width and the core-side model beside it.
`include "dbu_params.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [9:0]  ADDRESS = 10'h000;
  logic [31:0] WRITEDATA = 32'h0, PC_VALUE = 32'h0, MEM_ADDR = 32'h0, RES_ID = 32'h0, CFG_WDATA = 32'h0;
  logic [31:0] m_pc = 32'h0000_4000, m_sp = 32'h0001_fff0;
  logic [2:0]  CALL_THREAD = 3'h0, PC_THREAD = 3'h0, MEM_THREAD = 3'h0, RES_THREAD = 3'h0, CFG_INDEX = 3'h0;
  logic [3:0]  BYTEENABLE = 4'hf, lat = 4'h0;
  logic        READ = 1'b0, WRITE = 1'b0, HOST_REQ = 1'b0, CALL_VALID = 1'b0, PC_VALID = 1'b0;
  logic        MEM_VALID = 1'b0, MEM_LOAD = 1'b0, RES_VALID = 1'b0, CFG_WRITE = 1'b0, rel = 1'b0;
  logic [31:0] READDATA, ENTRY_PC, ENTRY_SP, CFG_RDATA;
  logic [7:0]  THREAD_HALT, STATE_READ_THREAD, exp_run = 8'h00;
  logic [4:0]  STATE_READ_REG;
  logic        WAITREQUEST, DEBUG_REQ, IN_DEBUG, ENTRY_STROBE, DEBUG_RETURN;
  int          n_errors = 0, cmp_count = 0;

  dbu_top i_dbu_top (.CLK, .SYS_RST, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
    .WAITREQUEST, .HOST_REQ, .CALL_VALID, .CALL_THREAD, .PC_VALID, .PC_THREAD, .PC_VALUE, .MEM_VALID,
    .MEM_THREAD, .MEM_LOAD, .MEM_ADDR, .RES_VALID, .RES_THREAD, .RES_ID, .ENTRY_STROBE, .ENTRY_PC,
    .ENTRY_SP, .DEBUG_RETURN, .DEBUG_REQ, .IN_DEBUG, .THREAD_HALT, .STATE_READ_THREAD, .STATE_READ_REG,
    .CFG_WRITE, .CFG_INDEX, .CFG_WDATA, .CFG_RDATA);
  dbu_core_model i_dbu_core_model (.clk(CLK), .rst(SYS_RST), .debug_req(DEBUG_REQ), .in_debug(IN_DEBUG),
    .lat(lat), .release_req(rel), .pc(m_pc), .sp(m_sp), .entry_strobe(ENTRY_STROBE), .entry_pc(ENTRY_PC),
    .entry_sp(ENTRY_SP), .debug_return(DEBUG_RETURN));

  always #2.5 CLK = ~CLK;

  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then lets one edge pass
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    ADDRESS <= {i, 2'b00};
    WRITEDATA <= d;
    BYTEENABLE <= be;
    WRITE <= w;
    READ <= !w;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 40);
    q = READDATA;
    if (n >= 40) chk("bus answer", 32'h1, 32'h0);
    WRITE <= 1'b0;
    READ <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, 4'hf, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask

  function automatic logic [31:0] ty(input logic [2:0] c, input logic [1:0] u, input logic [7:0] t);
    return {14'h0, u, t, 5'h0, c};
  endfunction

  // Kind: 1 host, 2 call, 3 issue, 4 memory access, 5 resource access
  task automatic fire(input int k, input logic [2:0] t, input logic [31:0] v, input logic ld);
    {PC_THREAD, MEM_THREAD, RES_THREAD, CALL_THREAD} <= {t, t, t, t};
    {PC_VALUE, MEM_ADDR, RES_ID} <= {v, v, v};
    MEM_LOAD <= ld;
    {HOST_REQ, CALL_VALID, PC_VALID, MEM_VALID, RES_VALID} <= {k == 1, k == 2, k == 3, k == 4, k == 5};
    @(posedge CLK);
    {HOST_REQ, CALL_VALID, PC_VALID, MEM_VALID, RES_VALID} <= 5'h00;
  endtask

  task automatic quiet(input string nm);
    repeat (3) @(posedge CLK);
    chk(nm, 32'h0, {31'h0, DEBUG_REQ});
  endtask

  task automatic await(input logic dbg, input logic v);
    int n;
    n = 0;
    while (((dbg ? IN_DEBUG : DEBUG_REQ) !== v) && n < 30) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 30) chk("handshake wait", 32'h1, 32'h0);
  endtask

  task automatic session(input logic [31:0] et, input logic dk, input logic [31:0] ed);
    await(1'b0, 1'b1);
    rdc("cause info", `DBU_IDX_TYPE, et);
    if (dk) rdc("payload", `DBU_IDX_DATA, ed);
    await(1'b1, 1'b1);
    chk("halt in debug", 32'h0, {24'h0, THREAD_HALT});
    rdc("saved pc", `DBU_IDX_PC, m_pc);
    rdc("saved sp", `DBU_IDX_SP, m_sp);
    rel <= 1'b1;
    await(1'b1, 1'b0);
    rel <= 1'b0;
    @(posedge CLK);
    chk("halt after return", {24'h0, exp_run}, {24'h0, THREAD_HALT});
  endtask

  task automatic t_regs();
    logic [7:0]  ri [6] = '{`DBU_IDX_TNUM, `DBU_IDX_TREG, `DBU_IDX_RUN, `DBU_IDX_IBC + 8'h3, `DBU_IDX_DWC, 8'h01};
    logic [31:0] rm [6] = '{32'hff, 32'h1f, 32'hff, 32'h00ff_0003, 32'h00ff_0007, 32'h0};
    rdc("cause reset", `DBU_IDX_TYPE, 32'h0);
    foreach (ri[i]) begin
      rdc("reset value", ri[i], 32'h0);
      wr(ri[i], 32'hffff_ffff);
      rdc("field width", ri[i], rm[i]);
      wr(ri[i], 32'h0);
    end
    wr(`DBU_IDX_TNUM, 32'h0000_01a5);
    wr(`DBU_IDX_TREG, 32'h0000_0033);
    chk("thread operand", 32'ha5, {24'h0, STATE_READ_THREAD});
    chk("register operand", 32'h13, {27'h0, STATE_READ_REG});
  endtask

  task automatic t_mailbox();
    logic [31:0] q;
    wr(`DBU_IDX_SCR + 8'h3, 32'hcafe_0123);
    CFG_INDEX <= 3'h3;
    repeat (2) @(posedge CLK);
    chk("config view", 32'hcafe_0123, CFG_RDATA);
    {CFG_WDATA, CFG_INDEX, CFG_WRITE} <= {32'h5a5a_0007, 3'h7, 1'b1};
    @(posedge CLK);
    CFG_WRITE <= 1'b0;
    rdc("bus view", `DBU_IDX_SCR + 8'h7, 32'h5a5a_0007);
    bus(1'b1, `DBU_IDX_SCR + 8'h7, 32'h1111_11ee, 4'h1, q);
    rdc("byte lane", `DBU_IDX_SCR + 8'h7, 32'h5a5a_00ee);
  endtask

  task automatic t_code();
    wr(`DBU_IDX_IBA + 8'h2, 32'h0000_4000);
    wr(`DBU_IDX_IBA + 8'h3, 32'h0000_4000);
    wr(`DBU_IDX_IBC + 8'h2, 32'h0020_0001);
    wr(`DBU_IDX_IBC + 8'h3, 32'h0020_0001);
    fire(3, 3'h4, 32'h4000, 1'b0);
    quiet("thread disabled");
    fire(3, 3'h5, 32'h4004, 1'b0);
    quiet("pc mismatch");
    fire(3, 3'h5, 32'h4000, 1'b0);
    session(ty(`DBU_CAUSE_IBRK, 2'h2, 8'h05), 1'b0, 32'h0);
    wr(`DBU_IDX_IBC + 8'h2, 32'h0020_0003);
    fire(3, 3'h5, 32'h4004, 1'b0);
    session(ty(`DBU_CAUSE_IBRK, 2'h2, 8'h05), 1'b0, 32'h0);
    wr(`DBU_IDX_IBC + 8'h2, 32'h0);
    wr(`DBU_IDX_IBC + 8'h3, 32'h0);
  endtask

  task automatic t_mem();
    wr(`DBU_IDX_DWA1 + 8'h1, 32'h0000_1000);
    wr(`DBU_IDX_DWA2 + 8'h1, 32'h0000_1fff);
    wr(`DBU_IDX_DWC + 8'h1, 32'h0001_0001);
    fire(4, 3'h0, 32'h1800, 1'b1);
    quiet("load ignored");
    fire(4, 3'h0, 32'h2000, 1'b0);
    quiet("outside range");
    fire(4, 3'h1, 32'h1800, 1'b0);
    quiet("thread disabled");
    fire(4, 3'h0, 32'h1fff, 1'b0);
    session(ty(`DBU_CAUSE_DWAT, 2'h1, 8'h00), 1'b1, 32'h1fff);
    wr(`DBU_IDX_DWC + 8'h1, 32'h0001_0007);
    fire(4, 3'h0, 32'h0500, 1'b1);
    session(ty(`DBU_CAUSE_DWAT, 2'h1, 8'h00), 1'b1, 32'h0500);
    wr(`DBU_IDX_DWC + 8'h1, 32'h0);
  endtask

  task automatic t_res();
    lat <= 4'h9;
    wr(`DBU_IDX_RWM, 32'h0000_00ff);
    wr(`DBU_IDX_RWV, 32'h0000_0042);
    wr(`DBU_IDX_RWC, 32'h0004_0001);
    fire(5, 3'h2, 32'h1243, 1'b0);
    quiet("masked id differs");
    fire(5, 3'h2, 32'h7742, 1'b0);
    session(ty(`DBU_CAUSE_RWAT, 2'h0, 8'h02), 1'b1, 32'h7742);
    wr(`DBU_IDX_RWC, 32'h0004_0003);
    fire(5, 3'h2, 32'h7742, 1'b0);
    quiet("inverse condition");
    wr(`DBU_IDX_RWC, 32'h0);
  endtask

  task automatic t_host();
    exp_run = 8'h0a;
    wr(`DBU_IDX_RUN, 32'h0000_000a);
    chk("run mask", 32'h0a, {24'h0, THREAD_HALT});
    fire(1, 3'h6, 32'h0, 1'b0);
    session(ty(`DBU_CAUSE_HOST, 2'h0, 8'h00), 1'b0, 32'h0);
    lat <= 4'h0;
    fire(2, 3'h6, 32'h0, 1'b0);
    session(ty(`DBU_CAUSE_CALL, 2'h0, 8'h06), 1'b0, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_mailbox();
    t_code();
    t_mem();
    t_res();
    t_host();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    conclude();
  end
endmodule

`default_nettype wire
